// >>> clk_sel_pkg.sv
// Purpose: Shared constants for the target clock selector and status block
// Assumes: 125 MHz system clock, plain register port with 8-bit byte address
// Notes:   Offsets are byte addresses of 32-bit words
//
// Notes on behaviour
// - Six rates: 24, 12, 6, 3, 1.5 MHz, 750 kHz
// - Rate selection 3 (6 MHz) after reset
// - Any of the six selections is accepted
// - Amber when target absent, unpowered or low reference
// - Green only when connected, powered, reference good
// - Indicator off in suspend or detached, until resume
// - Target drivers released while suspended
// - Global or port suspend request enters suspend
// - Full speed on USB 1.1, high speed on 2.0
// - Data and mode change on falling clock only
package clk_sel_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and rates
	localparam int unsigned CLK_KHZ        = 125000;
	localparam int unsigned RATE_COUNT     = 6;
	localparam int unsigned RATE_KHZ [0:5] = '{24000, 12000, 6000, 3000, 1500, 750};
	localparam logic [2:0]  RATE_SEL_MIN   = 3'h1;
	localparam logic [2:0]  RATE_SEL_MAX   = 3'h6;
	localparam logic [2:0]  RATE_SEL_RESET = 3'h3;

	// Settle time after resume before the indicator is shown again
	localparam int unsigned SETTLE_NS     = 100;
	localparam int unsigned SETTLE_CYCLES = (SETTLE_NS * CLK_KHZ + 999999) / 1000000;

	////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  OFS_RATE     = 8'h00;
	localparam logic [7:0]  OFS_STATUS   = 8'h04;
	localparam logic [7:0]  OFS_TX       = 8'h08;
	localparam logic [7:0]  OFS_IRQ_STAT = 8'h0c;
	localparam logic [7:0]  OFS_IRQ_MASK = 8'h10;

	// Status fields
	localparam int ST_GREEN     = 0;
	localparam int ST_AMBER     = 1;
	localparam int ST_SUSPENDED = 2;
	localparam int ST_HIGHSPEED = 3;
	localparam int ST_TGT_GOOD  = 4;
	localparam int ST_TX_BUSY   = 5;

	// Transmit fields
	localparam int TX_DATA = 0;
	localparam int TX_MODE = 1;

	// Event bits, same layout for status and mask
	localparam int EV_W       = 4;
	localparam int EV_SUSPEND = 0;
	localparam int EV_RESUME  = 1;
	localparam int EV_TGT_CHG = 2;
	localparam int EV_BIT_OUT = 3;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

	////////////////////////////////////////////////////////////////////////////
	// Synchronised pin indices
	localparam int PIN_W        = 8;
	localparam int PIN_PRESENT  = 0;
	localparam int PIN_POWERED  = 1;
	localparam int PIN_REF_OK   = 2;
	localparam int PIN_VBUS     = 3;
	localparam int PIN_USB2     = 4;
	localparam int PIN_SUSP_GLB = 5;
	localparam int PIN_SUSP_PRT = 6;
	localparam int PIN_RESUME   = 7;

	// Power state of the link side
	typedef enum logic [2:0] {
		LINK_ACTIVE    = 3'b001,
		LINK_SUSPENDED = 3'b010,
		LINK_RESUMING  = 3'b100
	} link_e;

endpackage

// >>> pin_sync.sv
// Purpose: Two-stage synchroniser for a group of pin levels
// Assumes: Inputs are slow levels from outside the clock domain
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinOut
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_s;

	sync_s syncQ;
	sync_s syncD;

	// Shift one stage per cycle
	always_comb begin
		syncD        = syncQ;
		syncD.stage1 = pinIn;
		syncD.stage2 = syncQ.stage1;
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			syncQ <= '0;
		end else if (ce) begin
			syncQ <= syncD;
		end
	end

	assign pinOut = syncQ.stage2;
endmodule
`default_nettype wire

// >>> rate_nco.sv
// Purpose: Target serial clock generator from the system clock
// Assumes: Selection already limited to the legal range
// Notes:   Phase accumulator; edges carry one system cycle of jitter
`timescale 1ns/10ps
`default_nettype none
module rate_nco
	import clk_sel_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic [2:0] rateSel,
	output logic            serialClock,
	output logic            fallPulse,
	output logic            risePulse
);
	typedef struct packed {
		logic [31:0] acc;
		logic        sclk;
		logic        fall;
		logic        rise;
	} nco_s;

	nco_s ncoQ;
	nco_s ncoD;

	// Step per cycle: twice the rate, scaled to 2^32 per system clock
	function automatic logic [31:0] stepOf(input logic [2:0] sel);
		logic [63:0] num;
		num = 64'(RATE_KHZ[int'(sel - RATE_SEL_MIN)]) << 33;
		return 32'(num / 64'(CLK_KHZ));
	endfunction

	logic [32:0] sum;

	// Accumulate and toggle on carry
	always_comb begin
		ncoD      = ncoQ;
		sum       = {1'b0, ncoQ.acc} + {1'b0, stepOf(rateSel)};
		ncoD.acc  = sum[31:0];
		ncoD.fall = sum[32] & ncoQ.sclk;
		ncoD.rise = sum[32] & ~ncoQ.sclk;
		if (sum[32]) begin
			ncoD.sclk = ~ncoQ.sclk;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ncoQ <= '0;
		end else if (ce) begin
			ncoQ <= ncoD;
		end
	end

	assign serialClock = ncoQ.sclk;
	assign fallPulse   = ncoQ.fall;
	assign risePulse   = ncoQ.rise;
endmodule
`default_nettype wire

// >>> target_clock_select_status.sv
// Purpose: Target clock rate select, reference status indicator, suspend control
// Assumes: Pin levels from the USB core and target sense are asynchronous
// Notes:   Target pins are output only; enables are active low
`timescale 1ns/10ps
`default_nettype none
module target_clock_select_status (
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  wire logic                           ce,
	// Register port
	input  wire logic [clk_sel_pkg::ADDR_W-1:0] addr,
	input  wire logic [31:0]                    wrData,
	input  wire logic                           wrEn,
	input  wire logic                           rdEn,
	output logic      [31:0]                    rdData,
	output logic                                irq,
	// Asynchronous sense pins
	input  wire logic                           targetPresent,
	input  wire logic                           targetPowered,
	input  wire logic                           refAboveThreshold,
	input  wire logic                           vbusPresent,
	input  wire logic                           hostPortUsb2,
	input  wire logic                           suspendGlobal,
	input  wire logic                           suspendPort,
	input  wire logic                           resumeRequest,
	// Attach speed and indicator
	output logic                                attachHighSpeed,
	output logic                                ledGreen,
	output logic                                ledAmber,
	// Target side pins
	output logic                                targetSerialClock,
	output logic                                targetSerialClockOe_n,
	output logic                                targetModeSelectOut,
	output logic                                targetModeSelectOe_n,
	output logic                                targetDataOut,
	output logic                                targetDataOe_n
);
	import clk_sel_pkg::*;

	typedef struct packed {
		link_e             link;
		logic [2:0]        rateSel;
		logic              txPend;
		logic              txData;
		logic              txMode;
		logic              dataOut;
		logic              modeOut;
		logic              oe_n;
		logic              ledGreen;
		logic              ledAmber;
		logic              highSpeed;
		logic              vbus;
		logic              tgtGood;
		logic [EV_W-1:0]   irqStat;
		logic [EV_W-1:0]   irqMask;
		logic              irq;
		logic [31:0]       rdData;
		logic [3:0]        settle;
	} state_s;

	localparam state_s STATE_RESET = '{
		link:      LINK_ACTIVE,
		rateSel:   RATE_SEL_RESET,
		oe_n:      1'b0,
		irqMask:   IRQ_MASK_RESET,
		default:   '0
	};

	localparam logic [3:0] SETTLE_LOAD = 4'(SETTLE_CYCLES);

	state_s q;
	state_s d;

	logic [PIN_W-1:0] pins;
	logic             serialClock;
	logic             fallPulse;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser and clock generator
	pin_sync #(
		.WIDTH (PIN_W)
	) u_pin_sync (
		.clk    (clk),
		.rst_n  (rst_n),
		.ce     (ce),
		.pinIn  ({resumeRequest, suspendPort, suspendGlobal, hostPortUsb2,
		          vbusPresent, refAboveThreshold, targetPowered, targetPresent}),
		.pinOut (pins)
	);

	rate_nco u_rate_nco (
		.clk         (clk),
		.rst_n       (rst_n),
		.ce          (ce),
		.rateSel     (q.rateSel),
		.serialClock (serialClock),
		.fallPulse   (fallPulse),
		.risePulse   ()
	);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	logic            tgtGood;
	logic            suspReq;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] clr;

	always_comb begin
		d        = q;
		d.rdData = '0;
		ev       = '0;
		clr      = '0;
		tgtGood  = pins[PIN_PRESENT] & pins[PIN_POWERED] & pins[PIN_REF_OK];
		suspReq  = pins[PIN_SUSP_GLB] | pins[PIN_SUSP_PRT];

		// Register writes
		if (wrEn) begin
			unique case (addr)
				OFS_RATE: begin
					if (wrData[2:0] >= RATE_SEL_MIN && wrData[2:0] <= RATE_SEL_MAX) begin
						d.rateSel = wrData[2:0];
					end
				end
				OFS_TX: begin
					if (!q.txPend) begin
						d.txPend = 1'b1;
						d.txData = wrData[TX_DATA];
						d.txMode = wrData[TX_MODE];
					end
				end
				OFS_IRQ_STAT: clr       = wrData[EV_W-1:0];
				OFS_IRQ_MASK: d.irqMask = wrData[EV_W-1:0];
				default: ;
			endcase
		end

		// Power state sequencing
		unique case (q.link)
			LINK_ACTIVE: begin
				if (suspReq) begin
					d.link            = LINK_SUSPENDED;
					ev[EV_SUSPEND]    = 1'b1;
				end
			end
			LINK_SUSPENDED: begin
				if (pins[PIN_RESUME] && !suspReq) begin
					d.link   = LINK_RESUMING;
					d.settle = SETTLE_LOAD;
				end
			end
			LINK_RESUMING: begin
				if (suspReq) begin
					d.link = LINK_SUSPENDED;
				end else if (q.settle == 4'h0) begin
					d.link         = LINK_ACTIVE;
					ev[EV_RESUME]  = 1'b1;
				end else begin
					d.settle = q.settle - 4'h1;
				end
			end
			default: d.link = LINK_SUSPENDED;
		endcase

		d.oe_n = (d.link == LINK_SUSPENDED);

		if (fallPulse && q.txPend && d.link != LINK_SUSPENDED) begin
			d.dataOut       = q.txData;
			d.modeOut       = q.txMode;
			d.txPend        = 1'b0;
			ev[EV_BIT_OUT]  = 1'b1;
		end

		// Target status tracking
		d.tgtGood = tgtGood;
		d.vbus    = pins[PIN_VBUS];
		if (tgtGood != q.tgtGood) begin
			ev[EV_TGT_CHG] = 1'b1;
		end

		// indicator off unless active and attached
		d.ledGreen = 1'b0;
		d.ledAmber = 1'b0;
		if (d.link == LINK_ACTIVE && d.vbus) begin
			d.ledGreen = d.tgtGood;
			d.ledAmber = !d.tgtGood;
		end

		d.highSpeed = pins[PIN_VBUS] & pins[PIN_USB2];

		// Sticky events, set beats clear
		d.irqStat = (q.irqStat & ~clr) | ev;
		d.irq     = |(d.irqStat & d.irqMask);

		// Register reads
		if (rdEn) begin
			unique case (addr)
				OFS_RATE:     d.rdData = {29'h0, q.rateSel};
				OFS_STATUS: begin
					d.rdData[ST_GREEN]     = q.ledGreen;
					d.rdData[ST_AMBER]     = q.ledAmber;
					d.rdData[ST_SUSPENDED] = (q.link == LINK_SUSPENDED);
					d.rdData[ST_HIGHSPEED] = q.highSpeed;
					d.rdData[ST_TGT_GOOD]  = q.tgtGood;
					d.rdData[ST_TX_BUSY]   = q.txPend;
				end
				OFS_IRQ_STAT: d.rdData = {28'h0, q.irqStat};
				OFS_IRQ_MASK: d.rdData = {28'h0, q.irqMask};
				default:      d.rdData = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= STATE_RESET;
		end else if (ce) begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output assignments
	logic clkOutQ;

	// Retime the clock with the enables
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			clkOutQ <= 1'b0;
		end else if (ce) begin
			clkOutQ <= serialClock;
		end
	end

	assign rdData                = q.rdData;
	assign irq                   = q.irq;
	assign attachHighSpeed       = q.highSpeed;
	assign ledGreen              = q.ledGreen;
	assign ledAmber              = q.ledAmber;
	assign targetSerialClock     = clkOutQ;
	assign targetSerialClockOe_n = q.oe_n;
	assign targetModeSelectOut   = q.modeOut;
	assign targetModeSelectOe_n  = q.oe_n;
	assign targetDataOut         = q.dataOut;
	assign targetDataOe_n        = q.oe_n;

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	rate_reset_a: assert property ($rose(rst_n) |-> q.rateSel == RATE_SEL_RESET)
		else $error("rate selection not at default after reset");

	rate_range_a: assert property (q.rateSel >= RATE_SEL_MIN && q.rateSel <= RATE_SEL_MAX)
		else $error("rate selection outside table");

	rate_accept_a: assert property (ce && wrEn && addr == OFS_RATE && wrData[2:0] >= RATE_SEL_MIN
		&& wrData[2:0] <= RATE_SEL_MAX |=> q.rateSel == $past(wrData[2:0]))
		else $error("legal rate write not taken");

	amber_cond_a: assert property (ledAmber == (q.link == LINK_ACTIVE && q.vbus && !q.tgtGood))
		else $error("amber indicator wrong");

	green_cond_a: assert property (ledGreen |-> q.tgtGood && q.vbus && !ledAmber)
		else $error("green without good target");

	led_off_a: assert property (q.link != LINK_ACTIVE |-> !ledGreen && !ledAmber)
		else $error("indicator lit outside active state");

	drv_off_a: assert property (q.link == LINK_SUSPENDED
		|-> targetSerialClockOe_n && targetModeSelectOe_n && targetDataOe_n)
		else $error("target drivers on while suspended");

	susp_entry_a: assert property (ce && q.link == LINK_ACTIVE && suspReq |=> q.link == LINK_SUSPENDED)
		else $error("suspend request not honoured");

	speed_a: assert property (ce && pins[PIN_VBUS] |=> attachHighSpeed == $past(pins[PIN_USB2]))
		else $error("attach speed mismatch");

	fall_only_a: assert property (ce && !fallPulse |=> $stable(targetDataOut) && $stable(targetModeSelectOut))
		else $error("target data changed off falling edge");

	resume_hold_a: assert property (q.link == LINK_RESUMING |-> !targetDataOe_n && !ledGreen && !ledAmber)
		else $error("resume sequence wrong");

	////////////////////////////////////////////////////////////////////////////
	// Guards on the register port and the event flags
	//
	// A rate write outside the table must leave the running rate alone,
	// otherwise the generator would step from a table entry that is not there.
	// A transmit write is taken only while nothing is pending, so a second
	// write cannot overwrite a bit that the target has not yet seen.
	// Read data must fall back to zero after its one cycle, since the port
	// has no valid flag and a stale word would look like a fresh answer.
	// A sent bit and a clear in the same cycle must leave the flag set.
	// No bit may leave while the drivers are released, or the target would
	// see a change on a line that its own bias is holding.

	// Refused rate writes
	rate_refuse_a: assert property (ce && wrEn && addr == OFS_RATE
		&& (wrData[2:0] < RATE_SEL_MIN || wrData[2:0] > RATE_SEL_MAX) |=> $stable(q.rateSel))
		else $error("illegal rate write changed the rate");

	// Transmit write marks busy
	tx_take_a: assert property (ce && wrEn && addr == OFS_TX && !q.txPend |=> q.txPend)
		else $error("transmit write not taken");

	// Read data only in the answer cycle
	rd_idle_a: assert property (ce && !rdEn |=> rdData == 32'h0)
		else $error("read data outside answer cycle");

	// Set beats clear
	set_wins_a: assert property (ce && ev[EV_BIT_OUT] |=> q.irqStat[EV_BIT_OUT])
		else $error("bit sent event lost");

	// Nothing sent while released
	susp_hold_a: assert property (ce && q.link == LINK_SUSPENDED && d.link == LINK_SUSPENDED
		|=> $stable(targetDataOut) && $stable(targetModeSelectOut))
		else $error("target data changed while suspended");

	// Settle count stays within its load
	settle_a: assert property (q.link == LINK_RESUMING |-> q.settle <= SETTLE_LOAD)
		else $error("settle count out of range");

	suspend_cov: cover property (q.link == LINK_ACTIVE ##1 q.link == LINK_SUSPENDED);
	resume_cov:  cover property (q.link == LINK_RESUMING ##1 q.link == LINK_ACTIVE);
	bit_out_cov: cover property (q.txPend ##1 !q.txPend);
	green_cov:   cover property (ledGreen);
	tgt_chg_cov: cover property ($changed(q.tgtGood));
endmodule
`default_nettype wire

// >>> target_port_model.sv
// Purpose: Target side of the serial configuration port
// Assumes: Target samples data and mode on rising clock
// Notes:   Released lines read as the target's pull-up
`timescale 1ns/10ps
`default_nettype none
module target_port_model (
	input  wire logic       sclk,
	input  wire logic       sclkOe_n,
	input  wire logic       dataOut,
	input  wire logic       dataOe_n,
	input  wire logic       modeOut,
	input  wire logic       modeOe_n,
	output logic      [1:0] lastBits,
	output int              badEdges
);
	logic lineClk;
	logic lineData;
	logic lineMode;
	////////////////////////////////////////
	// Undriven lines float to the bias level
	assign lineClk  = sclkOe_n ? 1'b1 : sclk;
	assign lineData = dataOe_n ? 1'b1 : dataOut;
	assign lineMode = modeOe_n ? 1'b1 : modeOut;
	initial begin
		lastBits = 2'h0;
		badEdges = 0;
	end
	always @(posedge lineClk) begin
		lastBits <= {lineMode, lineData};
	end
	always @(dataOut or modeOut) begin
		#1;
		if (sclk === 1'b1 && sclkOe_n === 1'b0) begin
			badEdges++;
		end
	end
endmodule
`default_nettype wire

// >>> tb_target_clock_select_status.sv
// Purpose: Self-checking bench for target clock select and status
// Assumes: Sense pins are slow levels, ce held high except in the final freeze check
// Notes:   Rate rows in a table, suspend and interrupt by hand
`timescale 1ns/10ps
`default_nettype none
module tb_target_clock_select_status;
	import clk_sel_pkg::*;
	logic        clk, rst_n, ce, wrEn, rdEn, irq;
	logic [7:0]  addr;
	logic [31:0] wrData, rdData, rd;
	logic        present, powered, refOk, vbus, usb2, suspG, suspP, resume;
	logic        hs, ledG, ledA, sclk, sclkOe_n, mode, modeOe_n, data, dataOe_n;
	logic [1:0]  lastBits;
	int          badEdges, err_count, compares, cycles, n;
	logic [31:0] rowWr [8] = '{1, 2, 3, 4, 5, 6, 0, 7};
	logic [31:0] rowSel [8] = '{1, 2, 3, 4, 5, 6, 6, 6};

	target_clock_select_status i_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
		.addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
		.irq(irq), .targetPresent(present), .targetPowered(powered),
		.refAboveThreshold(refOk), .vbusPresent(vbus), .hostPortUsb2(usb2),
		.suspendGlobal(suspG), .suspendPort(suspP), .resumeRequest(resume),
		.attachHighSpeed(hs), .ledGreen(ledG), .ledAmber(ledA),
		.targetSerialClock(sclk), .targetSerialClockOe_n(sclkOe_n),
		.targetModeSelectOut(mode), .targetModeSelectOe_n(modeOe_n),
		.targetDataOut(data), .targetDataOe_n(dataOe_n));
	target_port_model i_target (.sclk(sclk), .sclkOe_n(sclkOe_n), .dataOut(data),
		.dataOe_n(dataOe_n), .modeOut(mode), .modeOe_n(modeOe_n),
		.lastBits(lastBits), .badEdges(badEdges));

	////////////////////////////////////////
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			test_done();
		end
	end

	////////////////////////////////////////
	// Shared tasks
	task automatic test_done();
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic waitCyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr   <= a;
		wrData <= d;
		wrEn   <= 1'b1;
		@(posedge clk);
		wrEn   <= 1'b0;
	endtask
	task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge clk);
		rdEn <= 1'b0;
		#1;
		d = rdData;
	endtask
	// Rising target clock edges in 1000 cycles, within one
	task automatic edgesNear(input int exp);
		logic prev;
		n    = 0;
		prev = sclk;
		repeat (1000) begin
			@(posedge clk);
			#1;
			if (sclk === 1'b1 && prev === 1'b0) n++;
			prev = sclk;
		end
		compares++;
		if (n > exp + 1 || n + 1 < exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, n, exp);
		end
	endtask

	////////////////////////////////////////
	// Main sequence
	initial begin
		{rst_n, wrEn, rdEn, suspG, suspP, resume} = 6'h0;
		{ce, present, powered, refOk, vbus, usb2} = 6'h3f;
		addr = 8'h00;
		wrData = 32'h0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		waitCyc(6);
		// Reset values and unmapped place
		rdReg(OFS_RATE, rd);
		check(rd, 32'h3);
		edgesNear(RATE_KHZ[2] * 8 / 1000);
		rdReg(OFS_STATUS, rd);
		check(rd, 32'h19);
		rdReg(OFS_IRQ_MASK, rd);
		check(rd, 32'h0);
		wrReg(8'h14, 32'hffffffff);
		rdReg(8'h14, rd);
		check(rd, 32'h0);
		check(irq, 1'b0);
		for (int i = 0; i < 8; i++) begin
			wrReg(OFS_RATE, rowWr[i]);
			rdReg(OFS_RATE, rd);
			check(rd, rowSel[i]);
			edgesNear(RATE_KHZ[rowSel[i] - 1] * 8 / 1000);
		end
		// Every sense combination
		for (int k = 0; k < 8; k++) begin
			@(posedge clk);
			{present, powered, refOk} <= k[2:0];
			waitCyc(6);
			check({ledG, ledA}, (k == 7) ? 2'b10 : 2'b01);
		end
		// Attach speed and detach blanking
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			{vbus, usb2} <= k[1:0];
			waitCyc(6);
			check(hs, k == 3);
			check({ledG, ledA}, k[1] ? 2'b10 : 2'b00);
		end
		// Bits out to the target, then interrupt
		wrReg(OFS_IRQ_STAT, 32'hf);
		for (int v = 0; v < 4; v++) begin
			wrReg(OFS_TX, v);
			for (int k = 0; k < 200; k++) begin
				rdReg(OFS_STATUS, rd);
				if (rd[ST_TX_BUSY] === 1'b0) break;
			end
			check(rd[ST_TX_BUSY], 1'b0);
			waitCyc(120);
			check(lastBits, v[1:0]);
		end
		rdReg(OFS_IRQ_STAT, rd);
		check(rd, 32'h8);
		check(irq, 1'b0);
		wrReg(OFS_IRQ_MASK, 32'h8);
		waitCyc(2);
		check(irq, 1'b1);
		wrReg(OFS_IRQ_STAT, 32'h8);
		waitCyc(2);
		check(irq, 1'b0);
		// Global then port suspend, each resumed
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			suspG <= (i == 0);
			suspP <= (i == 1);
			waitCyc(6);
			check({ledG, ledA, sclkOe_n, modeOe_n, dataOe_n}, 5'h07);
			@(posedge clk);
			{suspG, suspP} <= 2'b00;
			waitCyc(10);
			check({ledG, ledA, sclkOe_n, modeOe_n, dataOe_n}, 5'h07);
			@(posedge clk);
			resume <= 1'b1;
			waitCyc(3);
			@(posedge clk);
			resume <= 1'b0;
			waitCyc(3);
			check({ledG, ledA, sclkOe_n, modeOe_n, dataOe_n}, 5'h00);
			waitCyc(20);
			check({ledG, ledA, sclkOe_n, modeOe_n, dataOe_n}, 5'h10);
		end
		rdReg(OFS_IRQ_STAT, rd);
		check(rd[1:0], 2'b11);
		check(badEdges, 0);
		// Enable low freezes the generated clock
		@(posedge clk);
		ce <= 1'b0;
		waitCyc(2);
		rd[0] = sclk;
		waitCyc(100);
		check(sclk, rd[0]);
		@(posedge clk);
		ce <= 1'b1;
		test_done();
	end
endmodule
`default_nettype wire
